// file: include/dac_fifo_consts.svh
// Constants for the DAC input FIFO, its delay line controls and configuration registers
`ifndef DAC_FIFO_CONSTS_SVH
`define DAC_FIFO_CONSTS_SVH
`define FIFO_SLOTS 8
`define FIFO_PTR_W 3
`define FIFO_LAST_SLOT 3'h7
`define FIFO_FIRST_SLOT 3'h0
`define FIFO_RESET_DEPTH 3'h4
`define OFS_RX_DELAY_TAP_LOW 8'h5e
`define OFS_RX_DELAY_LINE_CONTROL 8'h5f
`define OFS_STARTUP_CONFIG_A 8'h79
`define OFS_CHIP_REVISION 8'h7f
`define OFS_STARTUP_CONFIG_B 8'h80
`define OFS_STARTUP_CONFIG_C 8'he1
`define RST_RX_DELAY_TAP_LOW 8'hff
`define RST_RX_DELAY_LINE_CONTROL 8'h07
`define RST_STARTUP_CONFIG 8'h00
`define BIT_DELAY_LINE_ON 3
`define COARSE_LSB 0
`define COARSE_MSB 1
`define TAP_CODE0 11'h000
`define TAP_CODE1 11'h007
`define TAP_CODE2 11'h07f
`define TAP_CODE3 11'h5ff
`define SYNC_STAGES 2
`endif

// file: include/dac_fifo_pkg.sv
// Types shared by the DAC input FIFO design
package dac_fifo_pkg;
  // Phase of the halving divider that times FIFO reads
  typedef enum logic [0:0] {
    PH_LOW = 1'b0,
    PH_HIGH = 1'b1
  } div_phase_e;
  // Delay line settings handed to the receiver
  typedef struct packed {
    logic input_delay_line_on;
    logic [10:0] coarse_tap;
    logic [7:0] fine_delay_tap_low;
  } delay_cfg_s;
  // Start-up settings handed to the core
  typedef struct packed {
    logic [7:0] startup_setting_a;
    logic [7:0] startup_setting_b;
    logic [7:0] startup_setting_c;
  } startup_cfg_s;
endpackage

// file: logic/pin_sync.sv
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
`include "dac_fifo_consts.svh"
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);
  logic [W-1:0] meta_q;
  // First stage feeds only the second stage
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      meta_q <= '0;
      sync <= '0;
    end
    else
    begin
      meta_q <= pin;
      sync <= meta_q;
    end
  end
endmodule // pin_sync

// file: logic/dac_input_fifo_latency_sync.sv
// Eight-slot DAC input FIFO with independent side resets, read divider and register file
`timescale 1ns/1ns
`include "dac_fifo_consts.svh"
module dac_input_fifo_latency_sync #(
  parameter int DATA_W = 16,
  parameter logic [2:0] RESET_DEPTH = `FIFO_RESET_DEPTH,
  parameter logic [7:0] CHIP_REVISION = 8'h5a // Value is arbitrary
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic source_data_clock,
  input wire logic [DATA_W-1:0] source_data,
  input wire logic frame_ref,
  input wire logic sync_ref,
  input wire logic interp_2x_on,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  output logic [DATA_W-1:0] dac_data,
  output logic dac_data_valid,
  output logic [2:0] fifo_depth,
  output logic read_phase,
  output dac_fifo_pkg::delay_cfg_s delay_cfg,
  output dac_fifo_pkg::startup_cfg_s startup_cfg
);
  logic [DATA_W:0] src_sync;
  logic [1:0] ref_sync;
  logic dclk_prev_q;
  logic frame_prev_q;
  logic sync_prev_q;
  logic wr_stb;
  logic rd_stb;
  logic frame_edge;
  logic sync_edge;
  logic [`FIFO_PTR_W-1:0] wptr_q;
  logic [`FIFO_PTR_W-1:0] rptr_q;
  logic [DATA_W-1:0] mem_q [`FIFO_SLOTS];
  dac_fifo_pkg::div_phase_e div_q;
  logic [7:0] tap_low_q;
  logic [7:0] line_ctrl_q;
  logic [7:0] cfg_a_q;
  logic [7:0] cfg_b_q;
  logic [7:0] cfg_c_q;
  logic [7:0] rdata_q;
  logic [DATA_W-1:0] dout_q;
  logic dout_valid_q;
  logic [2:0] depth_q;
  logic [10:0] coarse_tap;

  // Data and its clock share one synchroniser so they stay aligned
  pin_sync #(.W(DATA_W + 1)) u_src_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin({source_data_clock, source_data}),
    .sync(src_sync)
  );

  pin_sync #(.W(2)) u_ref_sync (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .pin({frame_ref, sync_ref}),
    .sync(ref_sync)
  );

  // Edge history of the synchronised pins
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dclk_prev_q <= 1'b0;
      frame_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end
    else
    begin
      dclk_prev_q <= src_sync[DATA_W];
      frame_prev_q <= ref_sync[1];
      sync_prev_q <= ref_sync[0];
    end
  end

  // A rising edge of the source clock is one written word
  assign wr_stb = src_sync[DATA_W] & ~dclk_prev_q;
  assign frame_edge = ref_sync[1] & ~frame_prev_q;
  assign sync_edge = ref_sync[0] & ~sync_prev_q;

  // Halving divider; sys_rst and the sync reference both force PH_LOW, so after power-up its phase is repeatable
  always_ff @(posedge mclk)
  begin
    if (sys_rst || sync_edge)
      div_q <= dac_fifo_pkg::PH_LOW;
    else
    begin
      case (div_q)
        dac_fifo_pkg::PH_LOW: div_q <= dac_fifo_pkg::PH_HIGH;
        dac_fifo_pkg::PH_HIGH: div_q <= dac_fifo_pkg::PH_LOW;
        default: div_q <= dac_fifo_pkg::PH_LOW;
      endcase
    end
  end

  // Reads every half-rate cycle with interpolation, otherwise every cycle; phase moves output by one cycle
  assign rd_stb = interp_2x_on ? (div_q == dac_fifo_pkg::PH_HIGH) : 1'b1;
  assign read_phase = div_q;

  // Write pointer, reset by sys_rst and the frame reference, not by the sync reference
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      wptr_q <= `FIFO_FIRST_SLOT;
    else if (frame_edge)
      wptr_q <= `FIFO_FIRST_SLOT;
    else if (wr_stb)
      wptr_q <= (wptr_q == `FIFO_LAST_SLOT) ? `FIFO_FIRST_SLOT : wptr_q + 3'h1;
  end

  // Read pointer, reset by the sync reference to sit the preset depth behind slot 0
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rptr_q <= `FIFO_FIRST_SLOT;
    else if (sync_edge)
      rptr_q <= `FIFO_FIRST_SLOT - RESET_DEPTH;
    else if (rd_stb)
      rptr_q <= (rptr_q == `FIFO_LAST_SLOT) ? `FIFO_FIRST_SLOT : rptr_q + 3'h1;
  end

  // Slots clear on reset so reads before the first write give zero, never unknown words
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < `FIFO_SLOTS; i++)
        mem_q[i] <= '0;
    end
    else if (wr_stb)
      mem_q[wptr_q] <= src_sync[DATA_W-1:0];
  end

  // Output word; a word waits as many reads as the depth before it leaves
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      dout_q <= '0;
      dout_valid_q <= 1'b0;
    end
    else
    begin
      dout_valid_q <= rd_stb;
      if (rd_stb)
        dout_q <= mem_q[rptr_q];
    end
  end

  // Depth is the slot distance from read pointer to write pointer
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      depth_q <= 3'h0;
    else
      depth_q <= wptr_q - rptr_q;
  end

  assign dac_data = dout_q;
  assign dac_data_valid = dout_valid_q;
  assign fifo_depth = depth_q;

  // Register writes; the revision register ignores writes
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      tap_low_q <= `RST_RX_DELAY_TAP_LOW;
      line_ctrl_q <= `RST_RX_DELAY_LINE_CONTROL;
      cfg_a_q <= `RST_STARTUP_CONFIG;
      cfg_b_q <= `RST_STARTUP_CONFIG;
      cfg_c_q <= `RST_STARTUP_CONFIG;
    end
    else if (reg_we)
    begin
      case (reg_addr)
        `OFS_RX_DELAY_TAP_LOW: tap_low_q <= reg_wdata;
        `OFS_RX_DELAY_LINE_CONTROL: line_ctrl_q <= {4'h0, reg_wdata[3:0]};
        `OFS_STARTUP_CONFIG_A: cfg_a_q <= reg_wdata;
        `OFS_STARTUP_CONFIG_B: cfg_b_q <= reg_wdata;
        `OFS_STARTUP_CONFIG_C: cfg_c_q <= reg_wdata;
        default: tap_low_q <= tap_low_q;
      endcase
    end
  end

  // Read data registered, unmapped offsets read zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      rdata_q <= 8'h00;
    else if (reg_re)
    begin
      case (reg_addr)
        `OFS_RX_DELAY_TAP_LOW: rdata_q <= tap_low_q;
        `OFS_RX_DELAY_LINE_CONTROL: rdata_q <= line_ctrl_q;
        `OFS_STARTUP_CONFIG_A: rdata_q <= cfg_a_q;
        `OFS_CHIP_REVISION: rdata_q <= CHIP_REVISION;
        `OFS_STARTUP_CONFIG_B: rdata_q <= cfg_b_q;
        `OFS_STARTUP_CONFIG_C: rdata_q <= cfg_c_q;
        default: rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_q;

  // Coarse code to tap value
  always_comb
  begin
    case (line_ctrl_q[`COARSE_MSB:`COARSE_LSB])
      2'h0: coarse_tap = `TAP_CODE0;
      2'h1: coarse_tap = `TAP_CODE1;
      2'h2: coarse_tap = `TAP_CODE2;
      2'h3: coarse_tap = `TAP_CODE3;
      default: coarse_tap = `TAP_CODE0;
    endcase
  end

  // Settings leave straight from their registers
  assign delay_cfg.input_delay_line_on = line_ctrl_q[`BIT_DELAY_LINE_ON];
  assign delay_cfg.coarse_tap = coarse_tap;
  assign delay_cfg.fine_delay_tap_low = tap_low_q;
  assign startup_cfg.startup_setting_a = cfg_a_q;
  assign startup_cfg.startup_setting_b = cfg_b_q;
  assign startup_cfg.startup_setting_c = cfg_c_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  AST_WPTR_WRAP: assert property (wr_stb && !frame_edge && wptr_q == 3'h7 |=> wptr_q == 3'h0)
    else $error("write pointer did not wrap");
  AST_RPTR_STEP: assert property (rd_stb && !sync_edge |=> rptr_q == 3'($past(rptr_q) + 3'h1))
    else $error("read pointer did not step");
  AST_DEPTH: assert property (##1 depth_q == 3'($past(wptr_q) - $past(rptr_q)))
    else $error("depth not pointer distance");
  AST_DOUT: assert property (rd_stb |=> dout_q == $past(mem_q[rptr_q]) && dout_valid_q)
    else $error("read word not presented");
  AST_SYNC_DEPTH: assert property (sync_edge |=> rptr_q == 3'(3'h0 - RESET_DEPTH))
    else $error("read side not preset");
  AST_FRAME: assert property (frame_edge |=> wptr_q == 3'h0)
    else $error("write side not reset");
  AST_DIV_FORCE: assert property (sync_edge |=> div_q == dac_fifo_pkg::PH_LOW ##1 div_q == dac_fifo_pkg::PH_HIGH)
    else $error("divider not forced");
  AST_HALF_RATE: assert property (interp_2x_on && rd_stb && !sync_edge ##1 interp_2x_on |-> !rd_stb)
    else $error("read faster than half rate");
  AST_WR_ONLY_ON_EDGE: assert property (!frame_edge && !wr_stb |=> $stable(wptr_q))
    else $error("write pointer moved without clock");
  AST_TAP3: assert property (reg_we && reg_addr == `OFS_RX_DELAY_LINE_CONTROL && reg_wdata[1:0] == 2'h3
                             |=> delay_cfg.coarse_tap == `TAP_CODE3)
    else $error("coarse map wrong");
  AST_LINE_ON: assert property (reg_we && reg_addr == `OFS_RX_DELAY_LINE_CONTROL |=>
                                delay_cfg.input_delay_line_on == $past(reg_wdata[`BIT_DELAY_LINE_ON]))
    else $error("delay line enable wrong");

  COV_WRAP: cover property (wr_stb && wptr_q == 3'h7);
  COV_SYNC_INTERP: cover property (sync_edge && interp_2x_on ##2 rd_stb);
  COV_DEPTH4: cover property (depth_q == 3'h4 && dout_valid_q);
endmodule // dac_input_fifo_latency_sync

// file: tb/dac_source_model.sv
// Behavioural model of the FPGA data source feeding words and data clock
`timescale 1ns/1ns
module dac_source_model (
  input wire logic mclk,
  input wire logic run,
  output logic source_data_clock,
  output logic [15:0] source_data
);
  logic [1:0] ph_q;
  logic [2:0] slot_q;
  initial
  begin
    ph_q = 2'h0;
    slot_q = 3'h0;
    source_data_clock = 1'b0;
    source_data = 16'h0000;
  end
  // Two cycles low, two high; data settles a cycle before each rise
  // Idle clock stands low and the data churns, so stale words never look valid
  always @(posedge mclk)
  begin
    if (run)
    begin
      ph_q <= ph_q + 2'h1;
      source_data_clock <= ph_q[1];
      if (ph_q == 2'h1)
        source_data <= {8'ha5, 5'h00, slot_q};
      if (ph_q == 2'h3)
        slot_q <= slot_q + 3'h1;
    end
    else
    begin
      source_data_clock <= 1'b0;
      source_data <= ~source_data;
    end
  end
endmodule // dac_source_model

// file: tb/dac_input_fifo_latency_sync_bench.sv
// Self-checking bench for the DAC input FIFO and its registers
`timescale 1ns/1ns
module dac_input_fifo_latency_sync_bench;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  logic frame_ref = 1'b0;
  logic sync_ref = 1'b0;
  logic interp_2x_on = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic sdc;
  logic [15:0] sdata;
  logic [7:0] reg_rdata;
  logic [15:0] dac_data;
  logic dac_data_valid;
  logic [2:0] fifo_depth;
  logic read_phase;
  dac_fifo_pkg::delay_cfg_s delay_cfg;
  dac_fifo_pkg::startup_cfg_s startup_cfg;
  int error_cnt = 0;
  int comparisons = 0;
  // Rows: address, reset value, written value, value read back (0x5a revision is arbitrary)
  logic [31:0] rows [7] = '{32'h5eff3c3c, 32'h5f07ab0b, 32'h79001818, 32'h7f5a115a,
    32'h8000adad, 32'he1001a1a, 32'h60005500};
  logic [10:0] taps [4] = '{11'h000, 11'h007, 11'h07f, 11'h5ff};

  always #20 mclk = ~mclk;

  dac_source_model src (.mclk(mclk), .run(run), .source_data_clock(sdc), .source_data(sdata));

  dac_input_fifo_latency_sync dut (.mclk(mclk), .sys_rst(sys_rst), .source_data_clock(sdc),
    .source_data(sdata), .frame_ref(frame_ref), .sync_ref(sync_ref), .interp_2x_on(interp_2x_on),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .dac_data(dac_data), .dac_data_valid(dac_data_valid),
    .fifo_depth(fifo_depth), .read_phase(read_phase), .delay_cfg(delay_cfg),
    .startup_cfg(startup_cfg));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_re <= 1'b0;
    @(posedge mclk);
    #1 d = reg_rdata;
  endtask

  // Bounded wait for depth four (sel 0) or a read pulse (sel 1)
  task automatic hunt(input int sel);
    comparisons++;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      #1;
      if ((sel == 0 && fifo_depth === 3'h4) || (sel == 1 && dac_data_valid === 1'b1))
        return;
    end
    error_cnt++;
    $display("unexpected at %0t: seen %h expected %h", $time, fifo_depth, sel);
    conclude();
  endtask

  // Main sequence; expected words carry their slot number in the low bits
  initial
  begin
    logic [7:0] d;
    int gap;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      rd(rows[i][31:24], d);
      check(d, rows[i][23:16]);
      wr(rows[i][31:24], rows[i][15:8]);
      rd(rows[i][31:24], d);
      check(d, rows[i][7:0]);
    end
    check(startup_cfg, 24'h18ad1a);
    $display("register rows done");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h5f, {4'h0, c[2], 1'b0, c[1:0]});
      #1 check(delay_cfg, {c[2], taps[c[1:0]], 8'h3c});
    end
    $display("delay codes done");
    // Fill all eight slots after a frame reset, then sync with half-rate reads
    @(posedge mclk);
    frame_ref <= 1'b1;
    repeat (4) @(posedge mclk);
    frame_ref <= 1'b0;
    run <= 1'b1;
    repeat (32) @(posedge mclk);
    run <= 1'b0;
    repeat (6) @(posedge mclk);
    interp_2x_on <= 1'b1;
    sync_ref <= 1'b1;
    // Let the sync edge pass both flops and preset the read side before looking at depth
    repeat (3) @(posedge mclk);
    hunt(0);
    hunt(1);
    check(dac_data, 16'ha504);
    for (int k = 5; k < 20; k++)
    begin
      gap = 0;
      do
      begin
        @(posedge mclk);
        #1 gap++;
      end
      while (dac_data_valid !== 1'b1 && gap < 9);
      check(gap, 2);
      check(read_phase, 1'b0);
      check(dac_data, {8'ha5, 5'h00, 3'(k)});
    end
    // Full-rate reads drain one slot per cycle, wrapping through zero
    @(posedge mclk);
    sync_ref <= 1'b0;
    interp_2x_on <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 d = {5'h00, fifo_depth};
    for (int k = 0; k < 8; k++)
    begin
      @(posedge mclk);
      #1 check(fifo_depth, 3'(d[2:0] - 3'h1));
      d = {5'h00, fifo_depth};
    end
    $display("data path done");
    // Second reset in mid-run brings back defined pointers and divider
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1 check({fifo_depth, dac_data_valid, read_phase}, 5'h00);
    check(delay_cfg, {1'b0, 11'h5ff, 8'hff});
    rd(8'h79, d);
    check(d, 8'h00);
    $display("reset done");
    conclude();
  end
endmodule // dac_input_fifo_latency_sync_bench
